/* rtl/cfg_regs.vh */
/*
 * Constants of the converter and commutation configuration bank:
 * register indices, byte addresses, field positions, reset values.
 * Assumes a 32-bit Avalon-MM slave, one aligned word per register,
 * byte address equal to four times the register index.
 */
// Notes on behaviour
// - converter write replaces all fields at once
// - request bit one injects conversion; reads zero
// - channel select: current, logic, buck, reserved
// - filter enable write one enables; reads zero
// - general depth codes give 8,16,32,64
// - supply depth codes give 32,16,8,1
// - reserved bits always read as zero
// - mode: six, three, single, single Hall
// - freewheel style only in single-input modes
// - brake: low, high, open, alternating
// - recirculation only in single Hall mode
`ifndef CFG_REGS_VH
`define CFG_REGS_VH

// register indices and byte addresses
`define CONV_CFG_IDX        8'h12
`define COMM_CFG_IDX        8'h13
`define STATUS_IDX          8'h20
`define CONV_CFG_ADDR       8'h48
`define COMM_CFG_ADDR       8'h4C
`define STATUS_ADDR         8'h80

// reset values
`define CONV_CFG_RST        16'h0000
`define COMM_CFG_RST        16'h0000

// converter register fields
`define CONV_REQ_BIT        0
`define CONV_CHAN_LSB       1
`define CONV_CHAN_MSB       2
`define CONV_FILT_BIT       3
`define CONV_GEN_LSB        4
`define CONV_GEN_MSB        5
`define CONV_SUP_LSB        6
`define CONV_SUP_MSB        7
`define CONV_USED_MASK      16'h00F6

// commutation register fields
`define COMM_MODE_LSB       0
`define COMM_MODE_MSB       2
`define COMM_FREEW_BIT      3
`define COMM_BRAKE_LSB      4
`define COMM_BRAKE_MSB      5
`define COMM_RECIRC_BIT     6
`define COMM_USED_MASK      16'h007F

// codes
`define CHAN_DIG_CURRENT    2'h0
`define CHAN_LOGIC_REG      2'h1
`define CHAN_BUCK           2'h2
`define CHAN_RESERVED       2'h3
`define MODE_SIX_INPUT      3'h0
`define MODE_THREE_INPUT    3'h1
`define MODE_SINGLE_INPUT   3'h2
`define MODE_SINGLE_HALL    3'h3
`define BRAKE_LOW_SIDE      2'h0
`define BRAKE_HIGH_SIDE     2'h1
`define BRAKE_HIGH_Z        2'h2
`define BRAKE_ALTERNATE     2'h3

// status register fields
`define STAT_PEND_BIT       0
`define STAT_FILT_BIT       1
`define STAT_ALT_BIT        2
`define STAT_MODE_OK_BIT    3
`define STAT_CHAN_OK_BIT    4

`endif

/* rtl/avs_handshake.v */
/*
 * Avalon-MM waitrequest sequencer for a single-word register slave.
 * Assumes the master holds read or write steady until it sees
 * waitrequest low; every access costs exactly one wait cycle.
 */
`timescale 1ns/1ns
module avs_handshake (
	input  wire sys_clk_i,
	input  wire srst_i,
	input  wire read_i,
	input  wire write_i,
	output wire waitrequest_o,
	output wire capture_o,
	output wire accept_o
);
	reg  ack_reg;
	reg  ack_next;
	wire req;

	assign req           = read_i | write_i;
	// first cycle: load read data; second cycle: complete
	assign capture_o     = req & ~ack_reg;
	assign accept_o      = req & ack_reg;
	assign waitrequest_o = req & ~ack_reg;

	always @* begin
		ack_next = capture_o;
	end

	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
		end
	end
endmodule // avs_handshake

/* rtl/adc_pwm_config_regs.v */
/*
 * Converter and commutation configuration bank with an Avalon-MM
 * register slave, on-demand request holding and decoded controls.
 * Assumes the converter sequencer and the brake logic run on
 * sys_clk_i and give one-cycle pulses conv_taken_i, brake_event_i.
 */
`timescale 1ns/1ns
`include "cfg_regs.vh"
module adc_pwm_config_regs (
	input  wire        sys_clk_i,
	input  wire        srst_i,
	input  wire [7:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output wire [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	input  wire        conv_taken_i,
	input  wire        brake_event_i,
	output wire        od_request_pending_o,
	output wire        od_filter_enable_o,
	output wire [1:0]  od_channel_o,
	output wire        od_channel_valid_o,
	output wire [6:0]  general_depth_o,
	output wire [5:0]  supply_depth_o,
	output wire [2:0]  comm_mode_o,
	output wire        comm_mode_valid_o,
	output wire        six_input_scheme_o,
	output wire        three_input_scheme_o,
	output wire        single_input_scheme_o,
	output wire        hall_scheme_o,
	output wire        diode_freewheel_o,
	output wire [1:0]  brake_cfg_o,
	output wire        brake_low_side_o,
	output wire        brake_high_side_o,
	output wire        brake_high_z_o,
	output wire        alt_recirc_o
);
	reg  [15:0] conv_cfg_reg;
	reg  [15:0] conv_cfg_next;
	reg  [15:0] comm_cfg_reg;
	reg  [15:0] comm_cfg_next;
	reg         pend_reg;
	reg         pend_next;
	reg         filt_reg;
	reg         filt_next;
	reg         alt_high_reg;
	reg         alt_high_next;
	reg  [31:0] rdata_reg;
	reg  [31:0] rdata_next;
	reg  [6:0]  gen_depth_reg;
	reg  [5:0]  sup_depth_reg;
	reg         chan_ok_reg;
	reg         mode_ok_reg;
	reg  [3:0]  scheme_reg;
	reg         diode_reg;
	reg  [2:0]  brake_side_reg;
	reg         recirc_reg;
	reg  [6:0]  gen_depth_next;
	reg  [5:0]  sup_depth_next;
	reg  [3:0]  scheme_next;
	reg  [2:0]  brake_side_next;
	wire        capture;
	wire        accept;
	wire        sel_conv;
	wire        sel_comm;
	wire        sel_stat;
	wire        wr_conv;
	wire        wr_comm;
	wire [1:0]  chan;
	wire [2:0]  mode;
	wire [1:0]  brake;
	wire        single_mode;
	wire [15:0] status_word;

	avs_handshake u_hs (
		.sys_clk_i     (sys_clk_i),
		.srst_i        (srst_i),
		.read_i        (avs_read_i),
		.write_i       (avs_write_i & ~avs_read_i),
		.waitrequest_o (avs_waitrequest_o),
		.capture_o     (capture),
		.accept_o      (accept)
	);

	// address decode, full byte address
	assign sel_conv = (avs_address_i == `CONV_CFG_ADDR);
	assign sel_comm = (avs_address_i == `COMM_CFG_ADDR);
	assign sel_stat = (avs_address_i == `STATUS_ADDR);
	assign wr_conv  = accept & avs_write_i & ~avs_read_i & sel_conv;
	assign wr_comm  = accept & avs_write_i & ~avs_read_i & sel_comm;

	assign chan  = conv_cfg_reg[`CONV_CHAN_MSB:`CONV_CHAN_LSB];
	assign mode  = comm_cfg_reg[`COMM_MODE_MSB:`COMM_MODE_LSB];
	assign brake = comm_cfg_reg[`COMM_BRAKE_MSB:`COMM_BRAKE_LSB];
	assign single_mode = (mode == `MODE_SINGLE_INPUT) |
		(mode == `MODE_SINGLE_HALL);

	// converter register: whole-word replacement
	always @* begin
		conv_cfg_next = conv_cfg_reg;
		if (wr_conv) begin
			// a disabled low lane leaves the fields at reset value
			conv_cfg_next = `CONV_CFG_RST;
			if (avs_byteenable_i[0]) begin
				// write-only bits are not stored, so they read 0
				conv_cfg_next = avs_writedata_i[15:0] &
					`CONV_USED_MASK;
			end
		end
	end

	// commutation register: per-lane write, reserved bits dropped
	always @* begin
		comm_cfg_next = comm_cfg_reg;
		if (wr_comm && avs_byteenable_i[0]) begin
			comm_cfg_next = avs_writedata_i[15:0] &
				`COMM_USED_MASK;
		end
	end

	// on-demand request held until the sequencer takes it
	always @* begin
		pend_next = pend_reg;
		filt_next = filt_reg;
		if (conv_taken_i) begin
			pend_next = 1'b0;
			filt_next = 1'b0;
		end
		// a new request in the taking cycle wins over the clear
		if (wr_conv && avs_byteenable_i[0]) begin
			if (avs_writedata_i[`CONV_REQ_BIT]) begin
				pend_next = 1'b1;
			end
			if (avs_writedata_i[`CONV_FILT_BIT]) begin
				filt_next = 1'b1;
			end
		end
	end

	// alternating brake side flips on each braking event
	always @* begin
		alt_high_next = alt_high_reg;
		if (brake != `BRAKE_ALTERNATE) begin
			alt_high_next = 1'b0;
		end else if (brake_event_i) begin
			alt_high_next = ~alt_high_reg;
		end
	end

	// averaging depths
	always @* begin
		case (conv_cfg_reg[`CONV_GEN_MSB:`CONV_GEN_LSB])
		2'h0: gen_depth_next = 7'h08;
		2'h1: gen_depth_next = 7'h10;
		2'h2: gen_depth_next = 7'h20;
		default: gen_depth_next = 7'h40;
		endcase
		case (conv_cfg_reg[`CONV_SUP_MSB:`CONV_SUP_LSB])
		2'h0: sup_depth_next = 6'h20;
		2'h1: sup_depth_next = 6'h10;
		2'h2: sup_depth_next = 6'h08;
		default: sup_depth_next = 6'h01;
		endcase
	end

	// commutation scheme and brake decode
	always @* begin
		case (mode)
		`MODE_SIX_INPUT: scheme_next = 4'h1;
		`MODE_THREE_INPUT: scheme_next = 4'h2;
		`MODE_SINGLE_INPUT: scheme_next = 4'h4;
		`MODE_SINGLE_HALL: scheme_next = 4'h8;
		default: scheme_next = 4'h0;
		endcase
		// {high_z, high_side, low_side}
		case (brake)
		`BRAKE_LOW_SIDE: brake_side_next = 3'h1;
		`BRAKE_HIGH_SIDE: brake_side_next = 3'h2;
		`BRAKE_HIGH_Z: brake_side_next = 3'h4;
		default: brake_side_next = alt_high_reg ? 3'h2 : 3'h1;
		endcase
	end

	assign status_word = {11'h000,
		chan != `CHAN_RESERVED,
		mode[2] == 1'b0,
		alt_high_reg,
		filt_reg,
		pend_reg};

	// read data, loaded in the wait cycle and held to completion
	always @* begin
		rdata_next = rdata_reg;
		if (capture) begin
			rdata_next = 32'h0000_0000;
			if (sel_conv) begin
				rdata_next = {16'h0000, conv_cfg_reg};
			end else if (sel_comm) begin
				rdata_next = {16'h0000, comm_cfg_reg};
			end else if (sel_stat) begin
				rdata_next = {16'h0000, status_word};
			end
		end
	end

	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			conv_cfg_reg   <= `CONV_CFG_RST;
			comm_cfg_reg   <= `COMM_CFG_RST;
			pend_reg       <= 1'b0;
			filt_reg       <= 1'b0;
			alt_high_reg   <= 1'b0;
			rdata_reg      <= 32'h0000_0000;
			gen_depth_reg  <= 7'h08;
			sup_depth_reg  <= 6'h20;
			chan_ok_reg    <= 1'b1;
			mode_ok_reg    <= 1'b1;
			scheme_reg     <= 4'h1;
			diode_reg      <= 1'b0;
			brake_side_reg <= 3'h1;
			recirc_reg     <= 1'b0;
		end else begin
			conv_cfg_reg   <= conv_cfg_next;
			comm_cfg_reg   <= comm_cfg_next;
			pend_reg       <= pend_next;
			filt_reg       <= filt_next;
			alt_high_reg   <= alt_high_next;
			rdata_reg      <= rdata_next;
			gen_depth_reg  <= gen_depth_next;
			sup_depth_reg  <= sup_depth_next;
			chan_ok_reg    <= (chan != `CHAN_RESERVED);
			mode_ok_reg    <= (mode[2] == 1'b0);
			scheme_reg     <= scheme_next;
			diode_reg      <= single_mode &
				comm_cfg_reg[`COMM_FREEW_BIT];
			brake_side_reg <= brake_side_next;
			recirc_reg     <= (mode == `MODE_SINGLE_HALL) &
				comm_cfg_reg[`COMM_RECIRC_BIT];
		end
	end

	assign avs_readdata_o        = rdata_reg;
	assign od_request_pending_o  = pend_reg;
	assign od_filter_enable_o    = filt_reg;
	assign od_channel_o          = chan;
	assign od_channel_valid_o    = chan_ok_reg;
	assign general_depth_o       = gen_depth_reg;
	assign supply_depth_o        = sup_depth_reg;
	assign comm_mode_o           = mode;
	assign comm_mode_valid_o     = mode_ok_reg;
	assign six_input_scheme_o    = scheme_reg[0];
	assign three_input_scheme_o  = scheme_reg[1];
	assign single_input_scheme_o = scheme_reg[2];
	assign hall_scheme_o         = scheme_reg[3];
	assign diode_freewheel_o     = diode_reg;
	assign brake_cfg_o           = brake;
	assign brake_low_side_o      = brake_side_reg[0];
	assign brake_high_side_o     = brake_side_reg[1];
	assign brake_high_z_o        = brake_side_reg[2];
	assign alt_recirc_o          = recirc_reg;
endmodule // adc_pwm_config_regs

/* bench/adc_pwm_config_regs_chk.sv */
/*
 * checker for the configuration bank: bus wait timing, readback
 * masking, request holding and decoded controls.
 * assumes a bind onto adc_pwm_config_regs, one clock domain.
 */
`timescale 1ns/1ns
module adc_pwm_config_regs_chk (
	input wire        sys_clk_i,
	input wire        srst_i,
	input wire [7:0]  avs_address_i,
	input wire        avs_read_i,
	input wire        avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0]  avs_byteenable_i,
	input wire [31:0] avs_readdata_o,
	input wire        avs_waitrequest_o,
	input wire        conv_taken_i,
	input wire        brake_event_i,
	input wire        od_request_pending_o,
	input wire [6:0]  general_depth_o,
	input wire [5:0]  supply_depth_o,
	input wire        six_input_scheme_o,
	input wire        three_input_scheme_o,
	input wire        single_input_scheme_o,
	input wire        hall_scheme_o,
	input wire        diode_freewheel_o,
	input wire [1:0]  brake_cfg_o,
	input wire        brake_low_side_o,
	input wire        brake_high_side_o,
	input wire        brake_high_z_o,
	input wire        alt_recirc_o
);
	// write data two cycles back, lines up with decoded outputs
	reg [15:0] wd1_reg;
	reg [15:0] wd2_reg;
	always @(posedge sys_clk_i) begin
		wd1_reg <= avs_writedata_i[15:0];
		wd2_reg <= wd1_reg;
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	sequence s_done;
		avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	endsequence
	sequence s_conv_wr;
		s_done ##0 avs_address_i == 8'h48;
	endsequence
	sequence s_comm_wr;
		s_done ##0 avs_address_i == 8'h4C;
	endsequence
	sequence s_toggle;
		brake_cfg_o == 2'h3 && $past(brake_cfg_o, 2) == 2'h3 &&
		brake_event_i && !$past(brake_event_i) ##1 !brake_event_i;
	endsequence
	a_wait_one: assert property ((avs_read_i || avs_write_i) &&
		avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("wait state longer than one cycle");
	a_conv_clean: assert property (avs_read_i && !avs_waitrequest_o &&
		avs_address_i == 8'h48 |-> (avs_readdata_o & 32'hFFFFFF09) == 32'h0)
		else $error("converter readback not masked");
	a_comm_clean: assert property (avs_read_i && !avs_waitrequest_o &&
		avs_address_i == 8'h4C |-> avs_readdata_o[31:7] == 25'h0)
		else $error("commutation readback not masked");
	a_pend_set: assert property (s_conv_wr ##0 avs_writedata_i[0]
		|=> od_request_pending_o)
		else $error("request not pending after write");
	a_pend_clear: assert property (conv_taken_i &&
		!(avs_write_i && avs_writedata_i[0]) |=> !od_request_pending_o)
		else $error("request still pending after take");
	a_conv_depth: assert property (s_conv_wr |=> ##1
		general_depth_o == (7'h08 << wd2_reg[5:4]) && supply_depth_o ==
		(wd2_reg[7:6] == 2'h3 ? 6'h01 : 6'h20 >> wd2_reg[7:6]))
		else $error("average depth decode wrong");
	a_mode_decode: assert property (s_comm_wr |=> ##1
		{six_input_scheme_o, three_input_scheme_o, single_input_scheme_o,
		hall_scheme_o} == (wd2_reg[2] ? 4'h0 : 4'h8 >> wd2_reg[1:0]))
		else $error("mode decode wrong");
	a_mode_gated: assert property (s_comm_wr |=> ##1
		diode_freewheel_o == (wd2_reg[3] && wd2_reg[2:1] == 2'h1) &&
		alt_recirc_o == (wd2_reg[6] && wd2_reg[2:0] == 3'h3))
		else $error("gated mode option wrong");
	a_brake_fixed: assert property (s_comm_wr ##0
		avs_writedata_i[5:4] != 2'h3 |=> ##1 {brake_low_side_o,
		brake_high_side_o, brake_high_z_o} == (3'h4 >> wd2_reg[5:4]))
		else $error("brake decode wrong");
	a_brake_toggle: assert property (s_toggle |=>
		brake_low_side_o == !$past(brake_low_side_o, 2) &&
		brake_high_side_o == $past(brake_low_side_o, 2))
		else $error("brake side did not alternate");
endmodule // adc_pwm_config_regs_chk

bind adc_pwm_config_regs adc_pwm_config_regs_chk u_adc_pwm_config_regs_chk (.*);

/* bench/adc_pwm_config_regs_tb_top.sv */
/*
 * bench: Avalon-MM master writing and reading back table rows,
 * then reset, partial writes, request holding and braking.
 * assumes the bound checker for decoded outputs.
 */
`timescale 1ns/1ns
module adc_pwm_config_regs_tb_top;
	reg         sys_clk_i, srst_i, avs_read_i, avs_write_i;
	reg         conv_taken_i, brake_event_i;
	reg  [7:0]  avs_address_i;
	reg  [31:0] avs_writedata_i, q;
	reg  [3:0]  avs_byteenable_i;
	reg  [39:0] rows [0:10];
	reg  [15:0] w;
	wire [31:0] avs_readdata_o;
	wire        avs_waitrequest_o, od_request_pending_o, od_filter_enable_o;
	wire        od_channel_valid_o, comm_mode_valid_o, six_input_scheme_o;
	wire        three_input_scheme_o, single_input_scheme_o, hall_scheme_o;
	wire        diode_freewheel_o, brake_low_side_o, brake_high_side_o;
	wire        brake_high_z_o, alt_recirc_o;
	wire [1:0]  od_channel_o, brake_cfg_o;
	wire [6:0]  general_depth_o;
	wire [5:0]  supply_depth_o;
	wire [2:0]  comm_mode_o;
	integer     mismatches, samples_checked, cycles, i;
	adc_pwm_config_regs u_adc_pwm_config_regs (.*);
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			mismatches = mismatches + 1;
			results;
		end
	end
	task results;
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input wr, input [7:0] a, input [31:0] d, input [3:0] be);
		@(posedge sys_clk_i);
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		// waitrequest looked at on rising edges only
		@(posedge sys_clk_i);
		while (avs_waitrequest_o !== 1'b0)
			@(posedge sys_clk_i);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(q, e);
	endtask
	// one isolated braking event, then time for the side to show
	task brk;
		repeat (2) @(posedge sys_clk_i);
		brake_event_i <= 1'b1;
		@(posedge sys_clk_i);
		brake_event_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
	endtask
	initial begin
		srst_i = 1'b1;
		{avs_read_i, avs_write_i, conv_taken_i, brake_event_i} = 4'h0;
		avs_address_i = 8'h00;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'hF;
		mismatches = 0;
		samples_checked = 0;
		cycles = 0;
		rows[0] = 40'h48FFFF00F6;
		rows[1] = 40'h4800120012;
		rows[2] = 40'h4800640064;
		rows[3] = 40'h4800860086;
		rows[4] = 40'h4CFFFF007F;
		rows[5] = 40'h4C00010001;
		rows[6] = 40'h4C001A001A;
		rows[7] = 40'h4C004B004B;
		rows[8] = 40'h4C00240024;
		rows[9] = 40'h4C00350035;
		rows[10] = 40'h4C00400040;
		repeat (10) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		for (i = 0; i < 11; i = i + 1) begin
			w = rows[i][31:16];
			bus(1'b1, rows[i][39:32], {16'h0, w}, 4'hF);
			rd(rows[i][39:32], {16'h0, rows[i][15:0]});
			if (rows[i][39:32] == 8'h48)
				chk({od_channel_valid_o, od_channel_o}, {w[2:1] != 2'h3, w[2:1]});
			else
				chk({comm_mode_valid_o, comm_mode_o, brake_cfg_o}, {!w[2], w[2:0], w[5:4]});
		end
		srst_i <= 1'b1;
		@(posedge sys_clk_i);
		srst_i <= 1'b0;
		rd(8'h48, 32'h0);
		rd(8'h4C, 32'h0);
		chk(general_depth_o, 7'h08);
		chk(supply_depth_o, 6'h20);
		chk(od_channel_valid_o, 1'b1);
		bus(1'b1, 8'h48, 32'h9, 4'hF);
		bus(1'b1, 8'h48, 32'hF0, 4'hF);
		chk({od_request_pending_o, od_filter_enable_o}, 2'h3);
		rd(8'h80, 32'h1B);
		bus(1'b1, 8'h48, 32'h0, 4'h2);
		rd(8'h48, 32'h0);
		@(posedge sys_clk_i);
		conv_taken_i <= 1'b1;
		@(posedge sys_clk_i);
		conv_taken_i <= 1'b0;
		@(posedge sys_clk_i);
		chk({od_request_pending_o, od_filter_enable_o}, 2'h0);
		bus(1'b1, 8'h50, 32'hFFFF, 4'hF);
		rd(8'h50, 32'h0);
		bus(1'b1, 8'h4C, 32'h36, 4'hF);
		bus(1'b1, 8'h4C, 32'h0, 4'h2);
		rd(8'h4C, 32'h36);
		brk;
		chk({brake_low_side_o, brake_high_side_o}, 2'h1);
		brk;
		chk({brake_low_side_o, brake_high_side_o}, 2'h2);
		results;
	end
endmodule // adc_pwm_config_regs_tb_top
